// ### core/pmcb_bank.sv
`timescale 1ns/1ps
`include "pmcb_consts.svh"
// What this block does
// RULE_01: Read 0xD7 returns output current peak.
// RULE_02: Read 0xDD returns unsigned output voltage peak.
// RULE_03: Read 0xDE returns input voltage peak.
// RULE_04: Read 0xDF returns external temperature peak.
// RULE_05: Read 0xE1 returns input current peak.
// RULE_06: Send byte 0xE3 restarts every peak tracker.
// RULE_07: Unlock 0xBD needed before erase or data.
// RULE_08: Byte write 0xBE prepares bulk programming.
// RULE_09: 0xBF moves one word, pointer advances.
// RULE_10: 0xE6 holds 7-bit address, default 0x4F.
// RULE_11: 0xDC run low hold, default 0xFBE8.
// RULE_12: 0xDB retry interval, default 0xFABC.
// RULE_13: 0xD5 pin low reaction, default 0xC0.
// RULE_14: 0xD2 mask selects faults driving pin.
// RULE_15: 0xD6 is read only, fixed 0xC0.
// RULE_16: 0xB4 user word, default zero, nonvolatile.
// RULE_17: 0xB8 returns inductor self heat, read only.
// RULE_18: Resets 0xD0=0x1F, 0xD1=0x09, 0xD4=0xD2.
// RULE_19: 0xE8 sense resistance, default 0xCA80, nonvolatile.
// RULE_20: Linear eleven: exponent 15:11, mantissa 10:0.
// RULE_21: Unsigned voltage words use exponent minus twelve.
// RULE_22: Store all saves, restore all reloads settings.
// RULE_23: Locked erase and data transactions are ignored.
// RULE_24: Writes to read-only commands set fault.
module pmcb_bank #(
  parameter logic [15:0] PART_CODE = 16'h5a5a // Arbitrary identification value.
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Command request from the bus engine.
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire pmcb_pkg::pmcb_kind_e cmd_kind,
  input wire pmcb_pkg::pmcb_word_t cmd_wdata,
  // Command answer.
  output logic rsp_valid,
  output pmcb_pkg::pmcb_word_t rsp_data,
  // Nonvolatile image commands.
  input wire logic store_all_req,
  input wire logic restore_all_req,
  // Measurements and monitored values.
  input wire logic meas_strobe,
  input wire pmcb_pkg::pmcb_word_t iout_meas,
  input wire pmcb_pkg::pmcb_word_t vout_meas,
  input wire pmcb_pkg::pmcb_word_t vin_meas,
  input wire pmcb_pkg::pmcb_word_t temp_meas,
  input wire pmcb_pkg::pmcb_word_t iin_meas,
  input wire pmcb_pkg::pmcb_word_t self_heat_val,
  input wire pmcb_pkg::pmcb_word_t maker_info_val,
  input wire pmcb_pkg::pmcb_word_t chip_current_val,
  input wire pmcb_pkg::pmcb_word_t pad_state_val,
  // Fault propagation.
  input wire pmcb_pkg::pmcb_word_t fault_flags,
  output logic gpio_fault_assert,
  // Communication fault flag.
  input wire logic cml_fault_clear,
  output logic cml_fault,
  // Settings steering the rest of the controller.
  output logic [6:0] bus_slave_address,
  output pmcb_pkg::pmcb_word_t retry_interval,
  output pmcb_pkg::pmcb_word_t run_low_hold_time,
  output logic [7:0] pin_low_reaction,
  output logic [7:0] channel_config,
  output logic [7:0] general_config,
  output logic [7:0] switching_engine_config,
  output pmcb_pkg::pmcb_word_t thermal_tau_inverse,
  output pmcb_pkg::pmcb_word_t thermal_theta,
  output pmcb_pkg::pmcb_word_t input_sense_resistance
);
  import pmcb_pkg::*;

  // Map a command code onto its settings slot; bit 4 marks a hit.
  function automatic logic [4:0] cfg_index(input logic [7:0] c);
    case (c)
      `PMCB_CMD_USER_WORD: cfg_index = 5'h10;
      `PMCB_CMD_TAU_INV: cfg_index = 5'h11;
      `PMCB_CMD_THETA: cfg_index = 5'h12;
      `PMCB_CMD_CHAN_CFG: cfg_index = 5'h13;
      `PMCB_CMD_GEN_CFG: cfg_index = 5'h14;
      `PMCB_CMD_PROP_MASK: cfg_index = 5'h15;
      `PMCB_CMD_PWM_CFG: cfg_index = 5'h16;
      `PMCB_CMD_PIN_REACT: cfg_index = 5'h17;
      `PMCB_CMD_RETRY: cfg_index = 5'h18;
      `PMCB_CMD_RESTART: cfg_index = 5'h19;
      `PMCB_CMD_SLAVE_ADDR: cfg_index = 5'h1a;
      `PMCB_CMD_SENSE_RES: cfg_index = 5'h1b;
      default: cfg_index = 5'h00;
    endcase
  endfunction : cfg_index

  // Reset value of each settings slot.
  function automatic logic [15:0] cfg_default(input logic [3:0] i);
    case (i)
      4'h0: cfg_default = `PMCB_RST_USER_WORD;
      4'h1: cfg_default = `PMCB_RST_TAU_INV;
      4'h2: cfg_default = `PMCB_RST_THETA;
      4'h3: cfg_default = `PMCB_RST_CHAN_CFG;
      4'h4: cfg_default = `PMCB_RST_GEN_CFG;
      4'h5: cfg_default = `PMCB_RST_PROP_MASK;
      4'h6: cfg_default = `PMCB_RST_PWM_CFG;
      4'h7: cfg_default = `PMCB_RST_PIN_REACT;
      4'h8: cfg_default = `PMCB_RST_RETRY;
      4'h9: cfg_default = `PMCB_RST_RESTART;
      4'ha: cfg_default = `PMCB_RST_SLAVE_ADDR;
      default: cfg_default = `PMCB_RST_SENSE_RES;
    endcase
  endfunction : cfg_default

  // Bits kept by each slot; byte slots keep the low byte, the address seven bits.
  function automatic logic [15:0] cfg_mask(input logic [3:0] i);
    case (i)
      4'h3, 4'h4, 4'h6, 4'h7: cfg_mask = `PMCB_MASK_BYTE;
      4'ha: cfg_mask = `PMCB_MASK_ADDR;
      default: cfg_mask = `PMCB_MASK_WORD;
    endcase
  endfunction : cfg_mask

  // Linear eleven value scaled by two to the sixteenth, as a signed integer.
  function automatic logic signed [42:0] l11_value(input logic [15:0] w);
    logic [4:0] sh;
    logic signed [42:0] m;
    sh = {~w[`PMCB_L11_EXP_MSB], w[`PMCB_L11_EXP_MSB-1:`PMCB_L11_EXP_LSB]};
    m = 43'(signed'(w[`PMCB_L11_MANT_MSB:0]));
    l11_value = m <<< sh;
  endfunction : l11_value

  // True when a new reading exceeds the held peak in its own format.
  function automatic logic peak_higher(input logic unsigned_fmt, input logic [15:0] nw,
                                       input logic [15:0] od);
    if (unsigned_fmt) begin
      peak_higher = nw > od;
    end else begin
      peak_higher = l11_value(nw) > l11_value(od);
    end
  endfunction : peak_higher

  logic [15:0] cfg_q [`PMCB_CFG_N];
  logic [15:0] nvm_q [`PMCB_CFG_N];
  logic [15:0] pk_q [`PMCB_PEAK_N];
  logic pk_vld_q [`PMCB_PEAK_N];
  logic [15:0] ee_mem [`PMCB_EE_DEPTH];
  logic [`PMCB_EE_AW-1:0] ee_ptr_q;
  logic [`PMCB_EE_AW-1:0] ee_ptr_d;
  logic ee_unlock_q;
  logic cml_q;
  logic gpio_q;
  logic rsp_valid_q;
  logic [15:0] rsp_data_q;
  logic [15:0] rd_word;
  logic [15:0] meas [`PMCB_PEAK_N];

  // Command decode.
  wire logic [4:0] cfg_hit = cfg_index(cmd_code);
  wire logic [3:0] cfg_ix = cfg_hit[3:0];
  wire logic is_ro = (cmd_code == `PMCB_CMD_MAKER_INFO) || (cmd_code == `PMCB_CMD_SELF_HEAT) ||
                     (cmd_code == `PMCB_CMD_OT_REACT) || (cmd_code == `PMCB_CMD_IOUT_MAX) ||
                     (cmd_code == `PMCB_CMD_VOUT_MAX) || (cmd_code == `PMCB_CMD_VIN_MAX) ||
                     (cmd_code == `PMCB_CMD_TEMP_MAX) || (cmd_code == `PMCB_CMD_IIN_MAX) ||
                     (cmd_code == `PMCB_CMD_CHIP_CUR) || (cmd_code == `PMCB_CMD_PAD_STATE) ||
                     (cmd_code == `PMCB_CMD_PART_CODE);
  wire logic is_ee = (cmd_code == `PMCB_CMD_EE_UNLOCK) || (cmd_code == `PMCB_CMD_EE_ERASE) ||
                     (cmd_code == `PMCB_CMD_EE_DATA);
  wire logic is_clr_code = cmd_code == `PMCB_CMD_PEAK_CLEAR;
  wire logic unmapped = !(cfg_hit[4] || is_ro || is_ee || is_clr_code);
  wire logic wr_cfg = cmd_valid && cmd_write && cfg_hit[4];
  wire logic peak_clear = cmd_valid && cmd_write && is_clr_code && (cmd_kind == PMCB_SEND_BYTE); // RULE_06
  wire logic wr_bad = cmd_valid && cmd_write && (is_ro || unmapped); // RULE_24
  wire logic ee_unlock_wr = cmd_valid && cmd_write && (cmd_code == `PMCB_CMD_EE_UNLOCK) &&
                            (cmd_kind == PMCB_BYTE); // RULE_07
  wire logic ee_erase = cmd_valid && cmd_write && (cmd_code == `PMCB_CMD_EE_ERASE) &&
                        ee_unlock_q; // RULE_08 RULE_23
  wire logic ee_access = cmd_valid && (cmd_code == `PMCB_CMD_EE_DATA) && ee_unlock_q; // RULE_23
  wire logic ee_wr = ee_access && cmd_write; // RULE_09

  // Measurement slots in tracker order: iout, vout, vin, temperature, iin.
  assign meas[0] = iout_meas;
  assign meas[1] = vout_meas;
  assign meas[2] = vin_meas;
  assign meas[3] = temp_meas;
  assign meas[4] = iin_meas;

  // Settings slots with their nonvolatile image; a bus write wins over a restore.
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < `PMCB_CFG_N; i++) begin
      if (sys_rst) begin
        cfg_q[i] <= cfg_default(4'(i)); // RULE_10 RULE_11 RULE_12 RULE_13 RULE_14 RULE_16 RULE_18 RULE_19
        nvm_q[i] <= cfg_default(4'(i));
      end else begin
        if (restore_all_req) begin
          cfg_q[i] <= nvm_q[i]; // RULE_22
        end
        if (wr_cfg && (cfg_ix == 4'(i))) begin
          cfg_q[i] <= cmd_wdata & cfg_mask(4'(i));
        end
        if (store_all_req) begin
          nvm_q[i] <= cfg_q[i]; // RULE_22
        end
      end
    end
  end

  // Peak trackers; a measurement in the clearing cycle becomes the new start.
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < `PMCB_PEAK_N; i++) begin
      if (sys_rst) begin
        pk_q[i] <= 16'h0000;
        pk_vld_q[i] <= 1'b0;
      end else if (meas_strobe && (peak_clear || !pk_vld_q[i] ||
                   peak_higher(i == 1, meas[i], pk_q[i]))) begin
        pk_q[i] <= meas[i]; // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05 RULE_20 RULE_21
        pk_vld_q[i] <= 1'b1;
      end else if (peak_clear) begin
        pk_q[i] <= 16'h0000;
        pk_vld_q[i] <= 1'b0; // RULE_06
      end
    end
  end

  // Bulk memory pointer: erase rewinds it, each unlocked data word advances it.
  assign ee_ptr_d = ee_erase ? '0 : (ee_access ? ee_ptr_q + 1'b1 : ee_ptr_q); // RULE_08 RULE_09
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ee_ptr_q <= '0;
      ee_unlock_q <= 1'b0;
    end else begin
      ee_ptr_q <= ee_ptr_d;
      ee_unlock_q <= ee_unlock_q || ee_unlock_wr; // RULE_07
    end
  end

  // Bulk memory words; contents are not cleared by reset.
  always_ff @(posedge sys_clk) begin
    if (ee_wr) begin
      ee_mem[ee_ptr_q] <= cmd_wdata; // RULE_09
    end
  end

  // Read selection for the addressed command.
  always_comb begin
    rd_word = 16'h0000;
    if (cfg_hit[4]) begin
      rd_word = cfg_q[cfg_ix];
    end else begin
      case (cmd_code)
        `PMCB_CMD_MAKER_INFO: rd_word = maker_info_val;
        `PMCB_CMD_SELF_HEAT: rd_word = self_heat_val; // RULE_17
        `PMCB_CMD_OT_REACT: rd_word = `PMCB_RST_OT_REACT; // RULE_15
        `PMCB_CMD_IOUT_MAX: rd_word = pk_q[0]; // RULE_01
        `PMCB_CMD_VOUT_MAX: rd_word = pk_q[1]; // RULE_02
        `PMCB_CMD_VIN_MAX: rd_word = pk_q[2]; // RULE_03
        `PMCB_CMD_TEMP_MAX: rd_word = pk_q[3]; // RULE_04
        `PMCB_CMD_IIN_MAX: rd_word = pk_q[4]; // RULE_05
        `PMCB_CMD_CHIP_CUR: rd_word = chip_current_val;
        `PMCB_CMD_PAD_STATE: rd_word = pad_state_val;
        `PMCB_CMD_PART_CODE: rd_word = PART_CODE;
        `PMCB_CMD_EE_UNLOCK: rd_word = {15'h0000, ee_unlock_q};
        `PMCB_CMD_EE_DATA: rd_word = ee_unlock_q ? ee_mem[ee_ptr_q] : 16'h0000; // RULE_23
        default: rd_word = 16'h0000;
      endcase
    end
  end

  // Answer, sticky fault and registered pin drive; a new fault wins over a clear.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 16'h0000;
      cml_q <= 1'b0;
      gpio_q <= 1'b0;
    end else begin
      rsp_valid_q <= cmd_valid;
      rsp_data_q <= (cmd_valid && !cmd_write) ? rd_word : 16'h0000;
      cml_q <= wr_bad || (cml_q && !cml_fault_clear); // RULE_24
      gpio_q <= |(fault_flags & cfg_q[5]); // RULE_14
    end
  end

  // Output wiring.
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign cml_fault = cml_q;
  assign gpio_fault_assert = gpio_q;
  assign thermal_tau_inverse = cfg_q[1];
  assign thermal_theta = cfg_q[2];
  assign channel_config = cfg_q[3][7:0];
  assign general_config = cfg_q[4][7:0];
  assign switching_engine_config = cfg_q[6][7:0];
  assign pin_low_reaction = cfg_q[7][7:0]; // RULE_13
  assign retry_interval = cfg_q[8]; // RULE_12
  assign run_low_hold_time = cfg_q[9]; // RULE_11
  assign bus_slave_address = cfg_q[10][6:0]; // RULE_10
  assign input_sense_resistance = cfg_q[11]; // RULE_19

  // Checks on the bank.
  wire logic rd_req = cmd_valid && !cmd_write;
  wire logic [15:0] output_current_max_w = pk_q[0];
  wire logic [15:0] vin_max_w = pk_q[2];
  AST_ADDR_RESET: assert property (@(posedge sys_clk) // RULE_10
    sys_rst ##1 !sys_rst && !restore_all_req
    |-> bus_slave_address == 7'h4f && retry_interval == 16'hfabc)
    else $error("address or retry default wrong after reset");
  AST_OT_FIXED: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_15
    rd_req && cmd_code == `PMCB_CMD_OT_REACT |=> rsp_valid && rsp_data == 16'h00c0)
    else $error("overheat reaction read not fixed value");
  AST_CLEAR_PEAKS: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_06
    peak_clear && !meas_strobe ##1 !meas_strobe && !peak_clear ##1 meas_strobe && !peak_clear
    |=> output_current_max_w == $past(iout_meas) && vin_max_w == $past(vin_meas))
    else $error("peak not restarted after clear");
  AST_IOUT_PEAK: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_01
    meas_strobe && !peak_clear && pk_vld_q[0] && !peak_higher(1'b0, iout_meas, pk_q[0])
    |=> $stable(output_current_max_w))
    else $error("output current peak fell");
  AST_VOUT_PEAK: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_02
    meas_strobe && pk_vld_q[1] && vout_meas > pk_q[1] |=> pk_q[1] == $past(vout_meas))
    else $error("output voltage peak missed");
  AST_TEMP_PEAK: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_04
    ##1 pk_vld_q[3] && !$past(peak_clear) && $past(pk_vld_q[3])
    |-> !peak_higher(1'b0, $past(pk_q[3]), pk_q[3]))
    else $error("temperature peak decreased");
  AST_IIN_READ: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_05
    rd_req && cmd_code == `PMCB_CMD_IIN_MAX |=> rsp_data == $past(pk_q[4]))
    else $error("input current peak read wrong");
  AST_LOCKED_EE: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_23
    !ee_unlock_q && cmd_valid && cmd_code == `PMCB_CMD_EE_DATA |=> $stable(ee_ptr_q))
    else $error("locked memory access moved pointer");
  AST_EE_WALK: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_09
    ee_access && !ee_erase |=> ee_ptr_q == $past(ee_ptr_q) + 8'h01)
    else $error("memory pointer did not advance");
  AST_RO_FAULT: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_24
    cmd_valid && cmd_write && is_ro
    |=> cml_fault && ($stable(output_current_max_w) || $past(meas_strobe)))
    else $error("read-only write not flagged");
  AST_CML_STICKY: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_24
    cml_fault && !cml_fault_clear |=> cml_fault)
    else $error("communication fault dropped without a clear");
  AST_GPIO_MASK: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_14
    1'b1 |=> gpio_fault_assert == |($past(fault_flags) & $past(cfg_q[5])))
    else $error("pin fault drive does not follow the mask");
  AST_UNLOCK_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_07
    ee_unlock_q |=> ee_unlock_q)
    else $error("memory unlock lost before reset");
  AST_ADDR_WRITE: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_10
    wr_cfg && cmd_code == `PMCB_CMD_SLAVE_ADDR |=> bus_slave_address == $past(cmd_wdata[6:0]))
    else $error("bus address write not kept");
  COV_CLEAR: cover property (@(posedge sys_clk) peak_clear ##[1:4] meas_strobe);
  COV_BULK: cover property (@(posedge sys_clk) ee_unlock_wr ##[1:8] ee_erase ##[1:8] ee_wr);
  COV_RESTORE: cover property (@(posedge sys_clk) store_all_req ##[1:8] restore_all_req);
  COV_RO_CLEAR: cover property (@(posedge sys_clk) wr_bad ##[1:4] cml_fault_clear);
endmodule : pmcb_bank

// ### core/pmcb_consts.svh
`ifndef PMCB_CONSTS_SVH
`define PMCB_CONSTS_SVH
// Command codes of the bank.
`define PMCB_CMD_USER_WORD 8'hb4
`define PMCB_CMD_MAKER_INFO 8'hb6
`define PMCB_CMD_SELF_HEAT 8'hb8
`define PMCB_CMD_TAU_INV 8'hb9
`define PMCB_CMD_THETA 8'hba
`define PMCB_CMD_EE_UNLOCK 8'hbd
`define PMCB_CMD_EE_ERASE 8'hbe
`define PMCB_CMD_EE_DATA 8'hbf
`define PMCB_CMD_CHAN_CFG 8'hd0
`define PMCB_CMD_GEN_CFG 8'hd1
`define PMCB_CMD_PROP_MASK 8'hd2
`define PMCB_CMD_PWM_CFG 8'hd4
`define PMCB_CMD_PIN_REACT 8'hd5
`define PMCB_CMD_OT_REACT 8'hd6
`define PMCB_CMD_IOUT_MAX 8'hd7
`define PMCB_CMD_RETRY 8'hdb
`define PMCB_CMD_RESTART 8'hdc
`define PMCB_CMD_VOUT_MAX 8'hdd
`define PMCB_CMD_VIN_MAX 8'hde
`define PMCB_CMD_TEMP_MAX 8'hdf
`define PMCB_CMD_IIN_MAX 8'he1
`define PMCB_CMD_PEAK_CLEAR 8'he3
`define PMCB_CMD_CHIP_CUR 8'he4
`define PMCB_CMD_PAD_STATE 8'he5
`define PMCB_CMD_SLAVE_ADDR 8'he6
`define PMCB_CMD_PART_CODE 8'he7
`define PMCB_CMD_SENSE_RES 8'he8
// Reset values.
`define PMCB_RST_USER_WORD 16'h0000
`define PMCB_RST_TAU_INV 16'h8000
`define PMCB_RST_THETA 16'h8000
`define PMCB_RST_CHAN_CFG 16'h001f
`define PMCB_RST_GEN_CFG 16'h0009
`define PMCB_RST_PROP_MASK 16'h2993
`define PMCB_RST_PWM_CFG 16'h00d2
`define PMCB_RST_PIN_REACT 16'h00c0
`define PMCB_RST_OT_REACT 16'h00c0
`define PMCB_RST_RETRY 16'hfabc
`define PMCB_RST_RESTART 16'hfbe8
`define PMCB_RST_SLAVE_ADDR 16'h004f
`define PMCB_RST_SENSE_RES 16'hca80
// Field masks of the stored words.
`define PMCB_MASK_WORD 16'hffff
`define PMCB_MASK_BYTE 16'h00ff
`define PMCB_MASK_ADDR 16'h007f
// Linear format fields and sizes.
`define PMCB_L11_EXP_MSB 15
`define PMCB_L11_EXP_LSB 11
`define PMCB_L11_MANT_MSB 10
`define PMCB_CFG_N 12
`define PMCB_PEAK_N 5
`define PMCB_EE_DEPTH 256
`define PMCB_EE_AW 8
`endif

// ### core/pmcb_pkg.sv
package pmcb_pkg;
  // Kind of bus transaction carried with a command code.
  typedef enum logic [1:0] {PMCB_SEND_BYTE, PMCB_BYTE, PMCB_WORD} pmcb_kind_e;
  typedef logic [15:0] pmcb_word_t;
endpackage : pmcb_pkg

// ### verif/pmcb_host.sv
`timescale 1ns/1ps
// Host model: one command per transaction, answer taken one edge after the request.
module pmcb_host (
  // Clock.
  input wire logic sys_clk,
  // Command request.
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output pmcb_pkg::pmcb_kind_e cmd_kind,
  output pmcb_pkg::pmcb_word_t cmd_wdata,
  // Command answer.
  input wire logic rsp_valid,
  input wire pmcb_pkg::pmcb_word_t rsp_data
);
  import pmcb_pkg::*;
  // Quiet bus at time zero.
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_kind = PMCB_WORD;
    cmd_wdata = 16'h0000;
  end
  // Called just after a rising edge; an absent answer reads as unknown so it never matches.
  task automatic xfer(input logic w, input logic [7:0] c, input pmcb_kind_e k,
                      input pmcb_word_t d, output pmcb_word_t r);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_kind = k;
    cmd_wdata = (k == PMCB_SEND_BYTE) ? 16'h0000 : d;
    @(posedge sys_clk);
    #1;
    r = (rsp_valid === 1'b1) ? rsp_data : 16'hxxxx;
    cmd_valid = 1'b0;
    cmd_code = ~c; // Released lines do not keep the last value.
    cmd_wdata = ~d;
    @(posedge sys_clk);
    #1;
  endtask : xfer
endmodule : pmcb_host

// ### verif/tb.sv
`timescale 1ns/1ps
// Self-checking bench of the manufacturer command bank.
module tb;
  import pmcb_pkg::*;
  localparam logic [7:0] RW_C [12] = '{8'hb4, 8'hb9, 8'hba, 8'hd0, 8'hd1, 8'hd2, 8'hd4, 8'hd5,
    8'hdb, 8'hdc, 8'he6, 8'he8};
  localparam logic [15:0] RW_D [12] = '{16'h0000, 16'h8000, 16'h8000, 16'h001f, 16'h0009,
    16'h2993, 16'h00d2, 16'h00c0, 16'hfabc, 16'hfbe8, 16'h004f, 16'hca80};
  localparam logic [7:0] PK_C [5] = '{8'hd7, 8'hdd, 8'hde, 8'hdf, 8'he1};
  localparam logic [7:0] LV_C [4] = '{8'hb8, 8'hb6, 8'he4, 8'he5};
  logic sys_clk, sys_rst, cmd_valid, cmd_write, rsp_valid, store_all_req, restore_all_req;
  logic meas_strobe, gpio_fault_assert, cml_fault_clear, cml_fault;
  logic [7:0] cmd_code, pin_low_reaction, channel_config, general_config, switching_engine_config;
  logic [6:0] bus_slave_address;
  pmcb_kind_e cmd_kind;
  pmcb_word_t cmd_wdata, rsp_data, fault_flags, retry_interval, run_low_hold_time, rd;
  pmcb_word_t thermal_tau_inverse, thermal_theta, input_sense_resistance;
  pmcb_word_t meas_v [5];
  pmcb_word_t live_v [4];
  pmcb_word_t pk [5];
  pmcb_word_t regs [12];
  pmcb_word_t ee [4];
  logic pkv [5];
  logic [15:0] seed;
  int fails, checked, cyc;

  pmcb_host host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_kind(cmd_kind), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));
  pmcb_bank dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_kind(cmd_kind), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .store_all_req(store_all_req),
    .restore_all_req(restore_all_req), .meas_strobe(meas_strobe), .iout_meas(meas_v[0]),
    .vout_meas(meas_v[1]), .vin_meas(meas_v[2]), .temp_meas(meas_v[3]), .iin_meas(meas_v[4]),
    .self_heat_val(live_v[0]), .maker_info_val(live_v[1]), .chip_current_val(live_v[2]),
    .pad_state_val(live_v[3]), .fault_flags(fault_flags), .gpio_fault_assert(gpio_fault_assert),
    .cml_fault_clear(cml_fault_clear), .cml_fault(cml_fault),
    .bus_slave_address(bus_slave_address), .retry_interval(retry_interval),
    .run_low_hold_time(run_low_hold_time), .pin_low_reaction(pin_low_reaction),
    .channel_config(channel_config), .general_config(general_config),
    .switching_engine_config(switching_engine_config), .thermal_tau_inverse(thermal_tau_inverse),
    .thermal_theta(thermal_theta), .input_sense_resistance(input_sense_resistance));

  // Clock of 5 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Hang guard: the whole sequence needs well under this many cycles.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      print_verdict();
    end
  end

  // Pseudo-random source, repeatable from its fixed start.
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd

  // Stored width of a setting: address keeps seven bits, byte settings eight.
  function automatic logic [15:0] msk(input logic [7:0] c);
    if (c == 8'he6) return 16'h007f;
    if (c inside {8'hd0, 8'hd1, 8'hd4, 8'hd5}) return 16'h00ff;
    return 16'hffff;
  endfunction : msk

  // Setting output that mirrors a command; unknown where the setting has no port.
  function automatic logic [15:0] port_of(input logic [7:0] c);
    case (c)
      8'hb9: return thermal_tau_inverse;
      8'hba: return thermal_theta;
      8'hd0: return {8'h00, channel_config};
      8'hd1: return {8'h00, general_config};
      8'hd4: return {8'h00, switching_engine_config};
      8'hd5: return {8'h00, pin_low_reaction};
      8'hdb: return retry_interval;
      8'hdc: return run_low_hold_time;
      8'he6: return {9'h000, bus_slave_address};
      8'he8: return input_sense_resistance;
      default: return 16'hxxxx;
    endcase
  endfunction : port_of

  // Signed linear value: exponent in the top five bits, mantissa in the low eleven.
  function automatic real l11(input logic [15:0] w);
    return $itor($signed(w[10:0])) * (2.0 ** $itor($signed(w[15:11])));
  endfunction : l11

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Byte commands travel as byte transactions, the rest as words.
  function automatic pmcb_kind_e kind_of(input logic [7:0] c);
    if (c inside {8'hbd, 8'hbe, 8'hd0, 8'hd1, 8'hd4, 8'hd5, 8'hd6, 8'he6}) return PMCB_BYTE;
    return PMCB_WORD;
  endfunction : kind_of

  task automatic wr(input logic [7:0] c, input pmcb_word_t d);
    host.xfer(1'b1, c, kind_of(c), d, rd);
  endtask : wr

  task automatic rd_chk(input logic [7:0] c, input pmcb_word_t exp);
    host.xfer(1'b0, c, kind_of(c), 16'h0000, rd);
    chk(rd, exp);
  endtask : rd_chk

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge sys_clk);
    #1;
    s = 1'b0;
  endtask : pulse

  // Odd mantissas keep each linear value to one encoding; voltage is plain unsigned.
  task automatic measure();
    for (int i = 0; i < 5; i++) begin
      meas_v[i] = (i == 1) ? rnd() : (rnd() | 16'h0001);
      if (!pkv[i] || ((i == 1) ? (meas_v[i] > pk[i]) : (l11(meas_v[i]) > l11(pk[i])))) begin
        pk[i] = meas_v[i];
        pkv[i] = 1'b1;
      end
    end
    pulse(meas_strobe);
  endtask : measure

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // Main sequence.
  initial begin
    {store_all_req, restore_all_req, meas_strobe, cml_fault_clear} = 4'h0;
    fault_flags = 16'h0000;
    meas_v = '{default: 16'h0000};
    live_v = '{default: 16'h0000};
    pkv = '{default: 1'b0};
    seed = 16'd58;
    sys_rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 12; i++) begin
      rd_chk(RW_C[i], RW_D[i]);
      if (!(RW_C[i] inside {8'hb4, 8'hd2})) chk(port_of(RW_C[i]), RW_D[i]);
    end
    rd_chk(8'hd6, 16'h00c0);
    for (int i = 0; i < 12; i++) begin
      regs[i] = rnd() & msk(RW_C[i]);
      wr(RW_C[i], regs[i]);
      rd_chk(RW_C[i], regs[i]);
      if (!(RW_C[i] inside {8'hb4, 8'hd2})) chk(port_of(RW_C[i]), regs[i]);
    end
    chk(cml_fault, 1'b0);
    foreach (LV_C[i]) begin
      wr(LV_C[i], rnd());
      chk(cml_fault, 1'b1);
      pulse(cml_fault_clear);
      chk(cml_fault, 1'b0);
    end
    wr(8'hd6, 16'h0011);
    chk(cml_fault, 1'b1);
    pulse(cml_fault_clear);
    rd_chk(8'hd6, 16'h00c0);
    pulse(store_all_req);
    wr(8'hb4, ~regs[0]);
    wr(8'he8, ~regs[11]);
    pulse(restore_all_req);
    rd_chk(8'hb4, regs[0]);
    chk(input_sense_resistance, regs[11]);
    repeat (16) begin
      fault_flags = rnd();
      @(posedge sys_clk);
      #1;
      chk(gpio_fault_assert, |(fault_flags & regs[5]));
    end
    foreach (LV_C[i]) begin
      live_v[i] = rnd();
      rd_chk(LV_C[i], live_v[i]);
    end
    measure();
    host.xfer(1'b1, 8'he3, PMCB_SEND_BYTE, 16'h0000, rd);
    pkv = '{default: 1'b0};
    foreach (PK_C[i]) rd_chk(PK_C[i], 16'h0000);
    host.xfer(1'b1, 8'he3, PMCB_SEND_BYTE, 16'h0000, rd);
    pkv = '{default: 1'b0};
    measure();
    foreach (PK_C[i]) rd_chk(PK_C[i], pk[i]);
    repeat (3) begin
      repeat (10) measure();
      foreach (PK_C[i]) rd_chk(PK_C[i], pk[i]);
    end
    wr(8'hbe, 16'h0000);
    wr(8'hbf, 16'h1234);
    rd_chk(8'hbf, 16'h0000);
    chk(cml_fault, 1'b0);
    wr(8'hbd, 16'h0001);
    wr(8'hbe, 16'h0000);
    foreach (ee[j]) begin
      ee[j] = rnd();
      wr(8'hbf, ee[j]);
    end
    wr(8'hbe, 16'h0000);
    foreach (ee[j]) rd_chk(8'hbf, ee[j]);
    print_verdict();
  end
endmodule : tb
